// *** shared/toeq_pkg.sv ***
package toeq_pkg;
	// Clock and ticker timing
	localparam int CLK_FREQ_HZ = 20000000;
	localparam int TICK_PERIOD_US = 1;
	localparam int TICK_CYCLES = (CLK_FREQ_HZ / 1000000) * TICK_PERIOD_US;
	localparam logic [4:0] TICK_LAST = 5'(TICK_CYCLES - 1);
	// Fault indicator flash half period in ms
	localparam int FLASH_HALF_MS = 250;
	localparam int FLASH_CYCLES = (CLK_FREQ_HZ / 1000) * FLASH_HALF_MS;
	localparam logic [23:0] FLASH_LAST = 24'(FLASH_CYCLES - 1);
	// Area and queue sizes
	localparam int ENTRY_BYTES = 4;
	localparam int AREA_SMALL_ENTRIES = 5;
	localparam int AREA_LARGE_ENTRIES = 15;
	localparam int AREA_SMALL_BYTES = AREA_SMALL_ENTRIES * ENTRY_BYTES;
	localparam int AREA_LARGE_BYTES = AREA_LARGE_ENTRIES * ENTRY_BYTES;
	localparam logic [3:0] AREA_SMALL_LAST = 4'(AREA_SMALL_ENTRIES - 1);
	localparam logic [3:0] AREA_LARGE_LAST = 4'(AREA_LARGE_ENTRIES - 1);
	localparam int QUEUE_DEPTH = 31;
	localparam int QUEUE_AW = 5;
	localparam logic [5:0] QUEUE_FULL_COUNT = 6'(QUEUE_DEPTH);
	// Field positions inside an entry
	localparam int OSB_CH0_BIT = 7;
	localparam int OSB_CH3_BIT = 4;
	localparam int SEQ_LAST_BIT = 6;
	localparam int SEQ_W = 6;
	localparam logic [5:0] SEQ_FIRST = 6'h01;
	localparam logic [3:0] OSB_RESERVED_ZERO = 4'h0;
	// Queue state codes
	localparam logic [7:0] QSC_OK = 8'h00;
	localparam logic [7:0] QSC_BAD_SEQ = 8'h01;
	localparam logic [7:0] QSC_EMPTY = 8'h02;
	localparam logic [7:0] QSC_FULL = 8'h03;
	localparam logic [7:0] QSC_LAST_FLAG = 8'h80;
	localparam logic [7:0] QSC_RESET = QSC_EMPTY;
	localparam logic [1:0] LAST_ID = 2'h1;
	localparam logic [1:0] NEXT_ID = 2'h3;

	// One timed edge entry as carried in four bytes of the image
	typedef struct packed {
		logic [7:0] output_state_byte;
		logic [7:0] entry_sequence_number;
		logic [15:0] entry_time_value;
	} toeq_entry_s;

	// Entry as kept in the queue
	typedef struct packed {
		logic [3:0] states;
		logic [5:0] seq;
		logic last;
		logic [15:0] time_value;
	} toeq_qword_s;
	localparam int QWORD_W = $bits(toeq_qword_s);

	// Intake sequence
	typedef enum logic [1:0] {
		TOEQ_IDLE = 2'b00,
		TOEQ_SCAN = 2'b01,
		TOEQ_DONE = 2'b11
	} toeq_state_e;

	// Output states from an image byte, channel 0 on bit 7
	function automatic logic [3:0] toeq_states(input logic [7:0] osb);
		toeq_states = {osb[OSB_CH3_BIT], osb[OSB_CH3_BIT + 1], osb[OSB_CH3_BIT + 2], osb[OSB_CH0_BIT]};
	endfunction

	// Next sequence number, wrapping inside 0..63
	function automatic logic [5:0] toeq_seq_inc(input logic [5:0] s);
		toeq_seq_inc = s + 6'h01;
	endfunction
endpackage

// *** core/toeq_queue_mem.sv ***
`timescale 1ns/1ps
// Queue storage: one write port, registered read port
module toeq_queue_mem import toeq_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_wr_en,
	input wire logic [QUEUE_AW-1:0] i_wr_addr,
	input wire logic [QWORD_W-1:0] i_wr_data,
	input wire logic [QUEUE_AW-1:0] i_rd_addr,
	output logic [QWORD_W-1:0] o_rd_data
);
	logic [QWORD_W-1:0] mem [0:QUEUE_DEPTH-1];

	// Write and registered read
	always_ff @(posedge i_core_clk) begin
		if (i_wr_en) begin
			mem[i_wr_addr] <= i_wr_data;
		end
		o_rd_data <= mem[i_rd_addr];
	end
endmodule // toeq_queue_mem

// *** core/toeq_top.sv ***
`timescale 1ns/1ps
// How it works
// - Outputs change at scheduled times from queued entries, not on receipt.
// - Each queued entry keeps output states plus a microsecond time value.
// - Area holds five entries (20 bytes) or fifteen (60 bytes), by setting.
// - Every entry is four bytes: state byte, sequence number, time word.
// - Queue holds at most 31 entries; more are not stored.
// - Four outputs, each with an indicator lit while the output is one.
// - Fault indicator lights on overload, short circuit or overtemperature.
// - Fault indicator flashes when configuration is in error.
// - Run indicator on while bus communication works, off otherwise.
// - State byte bit 7..4 drive channels 0..3; bits 3..0 must be zero.
// - A 32-bit microsecond ticker from reset; low word matches entry time.
// - Sequence bit 6 marks the last valid entry; later ones are ignored.
module toeq_top import toeq_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_reset_n,
	input wire logic i_area_large,
	input wire logic i_area_valid,
	output logic o_area_ready,
	input wire toeq_entry_s [AREA_LARGE_ENTRIES-1:0] i_area,
	input wire logic i_bus_ok,
	input wire logic i_config_error,
	input wire logic i_overload,
	input wire logic i_short_circuit,
	input wire logic i_overtemp,
	output logic [3:0] o_outputs,
	output logic [3:0] o_channel_led,
	output logic o_run_led,
	output logic o_module_fault_indicator,
	output logic [7:0] o_last_seq,
	output logic [7:0] o_next_seq,
	output logic [7:0] o_queue_state_code,
	output logic [7:0] o_entry_count,
	output logic [31:0] o_ticker
);
	// Pin level synchronisers (three stages, change on agreement of two and three)
	logic [4:0] sync1, sync2, sync3, pin_state;
	wire logic [4:0] pin_raw = {i_bus_ok, i_config_error, i_overload, i_short_circuit, i_overtemp};
	always_ff @(posedge i_core_clk) begin
		sync1 <= pin_raw;
		sync2 <= sync1;
		sync3 <= sync2;
	end
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			pin_state <= 5'h00;
		end else begin
			pin_state <= (sync2 & sync3) | (pin_state & (sync2 | sync3));
		end
	end
	wire logic bus_ok = pin_state[4];
	wire logic cfg_err = pin_state[3];
	wire logic out_fault = |pin_state[2:0];

	// Microsecond ticker
	logic [4:0] tick_div;
	logic [31:0] ticker;
	wire logic tick = (tick_div == TICK_LAST);
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			tick_div <= 5'h00;
			ticker <= 32'h0000_0000;
		end else begin
			tick_div <= tick ? 5'h00 : tick_div + 5'h01;
			ticker <= tick ? ticker + 32'h0000_0001 : ticker;
		end
	end

	// Two-entry skid buffer between intake and queue
	toeq_qword_s buf_q [0:1];
	logic [1:0] buf_cnt;
	logic buf_rp, buf_wp;
	logic push_v;
	toeq_qword_s push_w;
	logic [5:0] q_count;
	wire logic q_full = (q_count == QUEUE_FULL_COUNT);
	wire logic buf_out_v = (buf_cnt != 2'h0);
	wire logic buf_in_rdy = (buf_cnt != 2'h2);
	wire logic q_wr = buf_out_v && !q_full;
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			buf_cnt <= 2'h0;
			buf_rp <= 1'b0;
			buf_wp <= 1'b0;
		end else begin
			if (push_v) begin
				buf_q[buf_wp] <= push_w;
				buf_wp <= ~buf_wp;
			end
			if (q_wr) begin
				buf_rp <= ~buf_rp;
			end
			buf_cnt <= buf_cnt + 2'(push_v) - 2'(q_wr);
		end
	end

	// Intake: walk the area one entry per cycle
	toeq_state_e state;
	logic [3:0] idx;
	logic [5:0] expect_seq;
	logic [7:0] sts_base;
	toeq_entry_s area_q [0:AREA_LARGE_ENTRIES-1];
	wire logic [3:0] area_last = i_area_large ? AREA_LARGE_LAST : AREA_SMALL_LAST;
	wire toeq_entry_s cur = area_q[idx];
	wire logic [5:0] cur_seq = cur.entry_sequence_number[SEQ_W-1:0];
	wire logic cur_last = cur.entry_sequence_number[SEQ_LAST_BIT];
	wire logic seq_good = (cur_seq == expect_seq);
	wire logic rsv_good = (cur.output_state_byte[3:0] == OSB_RESERVED_ZERO);
	wire logic scanning = (state == TOEQ_SCAN);
	wire logic room = buf_in_rdy && ((q_count + 6'(buf_cnt)) < QUEUE_FULL_COUNT);
	wire logic take = scanning && seq_good && rsv_good && room;
	wire logic stop = scanning && (!seq_good || !rsv_good || !room || cur_last || idx == area_last);
	assign push_v = take;
	assign push_w = '{states: toeq_states(cur.output_state_byte), seq: cur_seq, last: cur_last,
		time_value: cur.entry_time_value};
	assign o_area_ready = (state == TOEQ_IDLE);
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			state <= TOEQ_IDLE;
			idx <= 4'h0;
			expect_seq <= SEQ_FIRST;
			sts_base <= QSC_RESET;
			o_last_seq <= {LAST_ID, 6'h00};
		end else begin
			unique case (state)
				TOEQ_IDLE: begin
					if (i_area_valid) begin
						for (int k = 0; k < AREA_LARGE_ENTRIES; k++) begin
							area_q[k] <= i_area[k];
						end
						idx <= 4'h0;
						state <= TOEQ_SCAN;
					end
				end
				TOEQ_SCAN: begin
					if (take) begin
						expect_seq <= toeq_seq_inc(cur_seq);
						o_last_seq <= {LAST_ID, cur_seq};
						sts_base <= QSC_OK;
					end else if (!room) begin
						sts_base <= QSC_FULL;
					end else begin
						sts_base <= QSC_BAD_SEQ;
					end
					idx <= idx + 4'h1;
					if (stop) begin
						state <= TOEQ_DONE;
					end
				end
				TOEQ_DONE: begin
					state <= TOEQ_IDLE;
				end
				// Unused code 2'b10 falls back to idle
				default: begin
					state <= TOEQ_IDLE;
				end
			endcase
		end
	end

	// Queue pointers and executing head
	logic [4:0] q_wp, q_rp;
	logic [4:0] lastflag_cnt;
	toeq_qword_s head;
	logic [QWORD_W-1:0] rd_raw;
	logic head_v, head_fresh;
	wire toeq_qword_s rd_word = rd_raw;
	wire logic q_rd = head_v && (ticker[15:0] == head.time_value);
	wire logic [4:0] q_wp_next = (q_wp == 5'(QUEUE_DEPTH - 1)) ? 5'h00 : q_wp + 5'h01;
	wire logic [4:0] q_rp_next = (q_rp == 5'(QUEUE_DEPTH - 1)) ? 5'h00 : q_rp + 5'h01;
	toeq_queue_mem u_mem (
		.i_core_clk(i_core_clk),
		.i_wr_en(q_wr),
		.i_wr_addr(q_wp),
		.i_wr_data(buf_q[buf_rp]),
		.i_rd_addr(q_rp),
		.o_rd_data(rd_raw)
	);
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			q_wp <= 5'h00;
			q_rp <= 5'h00;
			q_count <= 6'h00;
			head_v <= 1'b0;
			head_fresh <= 1'b0;
			lastflag_cnt <= 5'h00;
			o_outputs <= 4'h0;
		end else begin
			if (q_wr) begin
				q_wp <= q_wp_next;
			end
			q_count <= q_count + 6'(q_wr) - 6'(q_rd);
			lastflag_cnt <= lastflag_cnt + 5'(q_wr && buf_q[buf_rp].last) - 5'(q_rd && head.last);
			// Head reloads two cycles after the read pointer settles
			head_fresh <= !head_v && (q_count != 6'h00) && !head_fresh;
			if (q_rd) begin
				o_outputs <= head.states;
				q_rp <= q_rp_next;
				head_v <= 1'b0;
			end else if (head_fresh) begin
				head <= rd_word;
				head_v <= 1'b1;
			end
		end
	end

	// Status and indicators
	logic [23:0] flash_cnt;
	logic flash;
	always_ff @(posedge i_core_clk) begin
		if (!i_reset_n) begin
			flash_cnt <= 24'h000000;
			flash <= 1'b0;
			o_module_fault_indicator <= 1'b0;
			o_run_led <= 1'b0;
			o_channel_led <= 4'h0;
			o_next_seq <= {NEXT_ID, 6'h00};
			o_queue_state_code <= QSC_RESET;
			o_entry_count <= 8'h00;
			o_ticker <= 32'h0000_0000;
		end else begin
			flash_cnt <= (flash_cnt == FLASH_LAST) ? 24'h000000 : flash_cnt + 24'h000001;
			flash <= (flash_cnt == FLASH_LAST) ? ~flash : flash;
			o_module_fault_indicator <= cfg_err ? flash : out_fault;
			o_run_led <= bus_ok;
			o_channel_led <= o_outputs;
			o_next_seq <= {NEXT_ID, head_v ? head.seq : 6'h00};
			o_queue_state_code <= (q_full ? QSC_FULL : (q_count == 6'h00) ? QSC_EMPTY : sts_base)
				| ((lastflag_cnt != 5'h00) ? QSC_LAST_FLAG : 8'h00);
			o_entry_count <= {2'h0, q_count};
			o_ticker <= ticker;
		end
	end
endmodule // toeq_top

// *** sim/toeq_properties.sv ***
`timescale 1ns/1ps
// Watches the block's pins for ticker, intake and indicator timing
module toeq_checker import toeq_pkg::*; (
	input logic i_core_clk,
	input logic i_reset_n,
	input logic i_area_valid,
	input logic o_area_ready,
	input logic i_bus_ok,
	input logic i_config_error,
	input logic i_overload,
	input logic i_short_circuit,
	input logic i_overtemp,
	input logic [3:0] o_outputs,
	input logic [3:0] o_channel_led,
	input logic o_run_led,
	input logic o_module_fault_indicator,
	input logic [7:0] o_last_seq,
	input logic [7:0] o_next_seq,
	input logic [31:0] o_ticker
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_reset_n);
	// Area taken, and any fault pin raised
	wire take = i_area_valid && o_area_ready;
	wire flt = i_overload || i_short_circuit || i_overtemp;
	ticker_step_a: assert property ($changed(o_ticker) |-> o_ticker == $past(o_ticker) + 32'h1)
		else $error("ticker jump");
	ticker_rate_a: assert property ($changed(o_ticker) |=> $stable(o_ticker)[*8])
		else $error("ticker too fast");
	intake_busy_a: assert property (take |=> !o_area_ready)
		else $error("ready during scan");
	scan_bound_a: assert property (take |-> ##[2:20] o_area_ready)
		else $error("scan too long");
	led_follow_a: assert property ($changed(o_outputs) |=> o_channel_led == $past(o_outputs))
		else $error("channel led wrong");
	run_led_a: assert property ($stable(i_bus_ok)[*6] |-> o_run_led == i_bus_ok)
		else $error("run led wrong");
	fault_pin_a: assert property ((!i_config_error && $stable(flt))[*6] |-> o_module_fault_indicator == flt)
		else $error("fault led wrong");
	seq_ident_a: assert property (o_last_seq[7:6] == LAST_ID && o_next_seq[7:6] == NEXT_ID)
		else $error("sequence id bits");
	take_c: cover property (take);
	fire_c: cover property ($changed(o_outputs));
	fault_c: cover property (o_module_fault_indicator);
endmodule // toeq_checker

bind toeq_top toeq_checker u_toeq_checker (.i_core_clk, .i_reset_n, .i_area_valid, .o_area_ready, .i_bus_ok,
	.i_config_error, .i_overload, .i_short_circuit, .i_overtemp, .o_outputs, .o_channel_led, .o_run_led,
	.o_module_fault_indicator, .o_last_seq, .o_next_seq, .o_ticker);

// *** sim/toeq_host_model.sv ***
`timescale 1ns/1ps
// Host side: offers one output area and holds it until taken
module toeq_host_model import toeq_pkg::*; (
	input logic i_core_clk,
	input logic i_area_ready,
	output logic o_area_valid,
	output toeq_entry_s [AREA_LARGE_ENTRIES-1:0] o_area
);
	initial begin
		o_area_valid = 1'b0;
		o_area = '0;
	end
	// Idle gap, then hold until the taking edge; scramble the area after release
	task automatic send(input toeq_entry_s [AREA_LARGE_ENTRIES-1:0] a, input int gap);
		repeat (gap + 1) @(posedge i_core_clk);
		o_area <= a;
		o_area_valid <= 1'b1;
		do @(posedge i_core_clk); while (i_area_ready !== 1'b1);
		o_area_valid <= 1'b0;
		o_area <= ~a;
	endtask
endmodule // toeq_host_model

// *** sim/toeq_top_tb_top.sv ***
`timescale 1ns/1ps
module toeq_top_tb_top import toeq_pkg::*; ();
	logic i_core_clk = 1'b0;
	logic i_reset_n = 1'b0;
	logic i_area_large = 1'b0;
	logic i_bus_ok = 1'b0;
	logic i_config_error = 1'b0;
	logic i_overload = 1'b0;
	logic i_short_circuit = 1'b0;
	logic i_overtemp = 1'b0;
	logic i_area_valid, o_area_ready, o_run_led, o_module_fault_indicator;
	logic [3:0] o_outputs, o_channel_led;
	logic [7:0] o_last_seq, o_next_seq, o_queue_state_code, o_entry_count;
	logic [31:0] o_ticker;
	toeq_entry_s [AREA_LARGE_ENTRIES-1:0] i_area, ar;
	logic [5:0] sq = 6'h01;
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	logic [31:0] tv;
	int nc = 0;

	always #25 i_core_clk = ~i_core_clk;

	toeq_top u_toeq_top (.i_core_clk, .i_reset_n, .i_area_large, .i_area_valid, .o_area_ready, .i_area,
		.i_bus_ok, .i_config_error, .i_overload, .i_short_circuit, .i_overtemp, .o_outputs, .o_channel_led,
		.o_run_led, .o_module_fault_indicator, .o_last_seq, .o_next_seq, .o_queue_state_code, .o_entry_count,
		.o_ticker);
	toeq_host_model u_host (.i_core_clk, .i_area_ready(o_area_ready), .o_area_valid(i_area_valid),
		.o_area(i_area));

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Cycle ceiling against a hang
	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// Channel order: state byte bit 7 drives channel 0
	function automatic logic [3:0] chs(input logic [7:0] s);
		return {s[4], s[5], s[6], s[7]};
	endfunction

	// Fifteen consecutively numbered entries, times spaced by step
	task automatic fill(input logic [7:0] s, input logic [15:0] t, input logic [15:0] step);
		for (int i = 0; i < 15; i++) begin
			ar[i] = {s, 2'b00, sq + 6'(i), t + step * 16'(i)};
		end
	endtask

	// Offer the area, wait for the scan and the queue write
	task automatic go(input int gap);
		u_host.send(ar, gap);
		@(posedge i_core_clk);
		for (int k = 0; k < 40 && o_area_ready !== 1'b1; k++) @(posedge i_core_clk);
		repeat (8) @(posedge i_core_clk);
	endtask

	task automatic wait_us(input logic [15:0] t);
		for (int k = 0; k < 9000 && o_ticker[15:0] < t; k++) @(posedge i_core_clk);
		repeat (3) @(posedge i_core_clk);
	endtask

	initial begin
		repeat (3) @(posedge i_core_clk);
		i_reset_n <= 1'b1;
		@(posedge i_core_clk);
		chk("last_seq", o_last_seq, 8'h40);
		chk("next_seq", o_next_seq, 8'hC0);
		chk("state", o_queue_state_code, QSC_RESET);
		// Ticker steps once per microsecond of clock
		tv = o_ticker;
		while (o_ticker == tv) @(posedge i_core_clk);
		tv = o_ticker;
		nc = 0;
		while (o_ticker == tv) begin
			@(posedge i_core_clk);
			nc++;
		end
		chk("tick_cycles", nc, TICK_CYCLES);
		$display("test reset done");
		// Each fault pin lights the fault indicator; run follows bus state
		for (int f = 0; f < 4; f++) begin
			{i_overload, i_short_circuit, i_overtemp} <= 3'b100 >> f;
			i_bus_ok <= f[0];
			repeat (8) @(posedge i_core_clk);
			chk("fault", o_module_fault_indicator, f < 3);
			chk("run_led", o_run_led, f[0]);
		end
		// Configuration error overrides a fault with the slow flash, dark in its first half period
		i_config_error <= 1'b1;
		i_overload <= 1'b1;
		repeat (8) @(posedge i_core_clk);
		chk("fault_flash", o_module_fault_indicator, 1'b0);
		i_config_error <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		chk("fault", o_module_fault_indicator, 1'b1);
		i_overload <= 1'b0;
		repeat (8) @(posedge i_core_clk);
		$display("test indicators done");
		// Timed execution; the marked third entry ends the area
		fill(8'hA0, 16'd20, 16'd20);
		ar[1].output_state_byte = 8'h50;
		ar[2].output_state_byte = 8'hF0;
		ar[2].entry_sequence_number[6] = 1'b1;
		go(0);
		sq = 6'h04;
		chk("count", o_entry_count, 8'h03);
		chk("last_seq", o_last_seq, 8'h43);
		chk("state", o_queue_state_code, QSC_OK | QSC_LAST_FLAG);
		chk("next_seq", o_next_seq, 8'hC1);
		for (int i = 0; i < 3; i++) begin
			wait_us(16'(20 * i + 21));
			chk("outputs", o_outputs, chs(ar[i].output_state_byte));
			chk("leds", o_channel_led, chs(ar[i].output_state_byte));
		end
		chk("count", o_entry_count, 8'h00);
		chk("last_flag", o_queue_state_code[7], 1'b0);
		$display("test timed done");
		// Small area takes five entries only
		fill(8'h00, 16'd150, 16'd1);
		go(3);
		sq = sq + 6'd5;
		chk("count", o_entry_count, 8'h05);
		chk("last_seq", o_last_seq, 8'h48);
		wait_us(16'd160);
		chk("outputs", o_outputs, 4'h0);
		$display("test small area done");
		// Refusals: reserved bit, then a wrong number after one good entry, then a good pair
		i_area_large <= 1'b1;
		fill(8'h10, 16'd300, 16'd1);
		ar[0].output_state_byte = 8'h11;
		go(0);
		chk("count", o_entry_count, 8'h00);
		chk("last_seq", o_last_seq, 8'h48);
		fill(8'h10, 16'd300, 16'd1);
		ar[1].entry_sequence_number = 8'h0C;
		go(0);
		sq = sq + 6'd1;
		chk("state", o_queue_state_code, QSC_BAD_SEQ);
		chk("last_seq", o_last_seq, 8'h49);
		chk("count", o_entry_count, 8'h01);
		fill(8'h10, 16'd300, 16'd1);
		ar[1].entry_sequence_number[6] = 1'b1;
		go(0);
		sq = sq + 6'd2;
		chk("last_seq", o_last_seq, 8'h4B);
		chk("count", o_entry_count, 8'h03);
		wait_us(16'd302);
		chk("outputs", o_outputs, chs(8'h10));
		$display("test refusal done");
		// Fill to capacity, then offer one more correctly numbered area
		for (int k = 0; k < 3; k++) begin
			fill(8'h00, 16'hF000, 16'h0000);
			go(0);
			sq = sq + 6'd15;
		end
		sq = 6'd43;
		fill(8'h00, 16'hF000, 16'h0000);
		go(0);
		chk("count", o_entry_count, 8'h1F);
		chk("last_seq", o_last_seq, 8'h6A);
		chk("state", o_queue_state_code, QSC_FULL);
		chk("next_seq", o_next_seq, 8'hCC);
		$display("test full done");
		complete_run();
	end
endmodule // toeq_top_tb_top
